/* rtl/sec_pkg.sv */
package sec_pkg;

	// Register window on the sub-addressed host port
	localparam logic [7:0] SYNC_TIMING_ADDR = 8'h8b;
	localparam logic [7:0] FSC_BYTE0_ADDR = 8'h8c;
	localparam logic [7:0] FSC_BYTE1_ADDR = 8'h8d;
	localparam logic [7:0] FSC_BYTE2_ADDR = 8'h8e;
	localparam logic [7:0] FSC_BYTE3_ADDR = 8'h8f;
	localparam logic [7:0] FSC_PHASE_ADDR = 8'h90;
	localparam logic [7:0] CC_EVEN_LOW_ADDR = 8'h91;
	localparam logic [7:0] CC_EVEN_HIGH_ADDR = 8'h92;
	localparam logic [7:0] CC_ODD_LOW_ADDR = 8'h93;
	localparam logic [7:0] CC_ODD_HIGH_ADDR = 8'h94;
	localparam logic [7:0] PED_ODD_A_ADDR = 8'h95;
	localparam logic [7:0] PED_ODD_B_ADDR = 8'h96;
	localparam logic [7:0] PED_EVEN_A_ADDR = 8'h97;
	localparam logic [7:0] PED_EVEN_B_ADDR = 8'h98;
	localparam logic [7:0] COPY_CTRL_TOP_ADDR = 8'h99;
	localparam logic [7:0] COPY_DATA_MID_ADDR = 8'h9a;
	localparam logic [7:0] COPY_DATA_LOW_ADDR = 8'h9b;
	localparam logic [7:0] SCALE_LSBS_ADDR = 8'h9c;
	localparam logic [7:0] LUMA_SCALE_ADDR = 8'h9d;
	localparam logic [7:0] BLUE_DIFF_SCALE_ADDR = 8'h9e;
	localparam logic [7:0] RED_DIFF_SCALE_ADDR = 8'h9f;
	localparam logic [7:0] HUE_ADDR = 8'ha0;
	localparam logic [7:0] BRIGHTNESS_ADDR = 8'ha1;
	localparam logic [7:0] LUMA_SHAPING_ADDR = 8'ha2;
	localparam logic [7:0] NOISE_CORING_ADDR = 8'ha3;

	localparam int NUM_REGS = 25;
	localparam int IDX_W = 5;

	// Reset values, indexed from the first register of the window
	localparam logic [7:0] RST_VAL [NUM_REGS] = '{
		8'h00, 8'h1f, 8'h7c, 8'hf0, 8'h21, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00
	};

	// Writable bits; reserved bits are held at zero
	localparam logic [7:0] WR_MASK [NUM_REGS] = '{
		8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
		8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
		8'hff, 8'hff, 8'hff, 8'h0f, 8'hff
	};

	// Sync timing register fields
	localparam int HS_WIDTH_LSB = 0;
	localparam int HS_VS_DELAY_LSB = 2;
	localparam int VS_RISE_EXT_BIT = 4;
	localparam int VS_WIDTH_LSB = 4;
	localparam int PIX_ADJ_LSB = 6;

	// Copy-generation control fields
	localparam int CGMS_TOP_LSB = 0;
	localparam int CGMS_CRC_BIT = 4;
	localparam int CGMS_ODD_BIT = 5;
	localparam int CGMS_EVEN_BIT = 6;
	localparam int WSS_EN_BIT = 7;

	// Scale LSB register fields
	localparam int LUMA_LSB_POS = 0;
	localparam int BLUE_LSB_POS = 2;
	localparam int RED_LSB_POS = 4;
	localparam int PHASE_LSB_POS = 6;

	localparam int WSS_BLANK_BIT = 7;
	localparam int BORDER_CORING_LSB = 0;
	localparam int DATA_CORING_LSB = 4;

	// Luma shaping gain: 0 dB code, used when the filter is not selected
	localparam logic [3:0] SHAPING_UNITY = 4'h6;
	localparam logic [3:0] CORING_MAX = 4'h8;

	// Timing codes, in pixel clock cycles
	localparam logic [7:0] PULSE_CYC0 = 8'h01;
	localparam logic [7:0] PULSE_CYC1 = 8'h04;
	localparam logic [7:0] PULSE_CYC2 = 8'h10;
	localparam logic [7:0] PULSE_CYC3 = 8'h80;
	localparam logic [4:0] DELAY_CYC0 = 5'h00;
	localparam logic [4:0] DELAY_CYC1 = 5'h04;
	localparam logic [4:0] DELAY_CYC2 = 5'h08;
	localparam logic [4:0] DELAY_CYC3 = 5'h12;

	// Extra vertical sync rising-edge delay
	localparam int CLK_MHZ = 200;
	localparam int RISE_EXT_US = 32;
	localparam int RISE_EXT_CYC = RISE_EXT_US * CLK_MHZ;
	localparam int CNT_W = 14;

	localparam logic [1:0] TIMING_MODE1 = 2'h1;
	localparam logic [1:0] TIMING_MODE2 = 2'h2;

	typedef enum logic [1:0] {
		VS_IDLE = 2'b00,
		VS_DELAY = 2'b01,
		VS_ACTIVE = 2'b10,
		VS_TRAIL = 2'b11
	} sec_vs_state_t;

	typedef struct packed {
		logic wrEn;
		logic rdEn;
		logic [7:0] subAddr;
		logic [7:0] wrData;
	} sec_host_req_t;

	typedef struct packed {
		logic [31:0] fscFreq;
		logic [9:0] fscPhase;
		logic [15:0] captionEvenExt;
		logic [15:0] captionOdd;
		logic [15:0] pedestalOffOdd;
		logic [15:0] pedestalOffEven;
		logic [19:0] cgmsData;
		logic [13:0] wssData;
		logic cgmsCrcEn;
		logic cgmsOddEn;
		logic cgmsEvenEn;
		logic wssEn;
		logic [9:0] lumaScale;
		logic [9:0] blueDifferenceScale;
		logic [9:0] redDifferenceScale;
		logic [7:0] hueOffset;
		logic [6:0] brightness;
		logic wssBlank;
		logic [3:0] lumaShapingFilterGain;
		logic signed [5:0] borderCoringGain;
		logic signed [5:0] dataCoringGain;
	} sec_cfg_t;

	typedef struct packed {
		logic hsyncN;
		logic vsyncN;
		logic pixelStart;
	} sec_sync_t;

endpackage : sec_pkg

/* rtl/sec_reg_file.sv */
`timescale 1ns/10ps
module sec_reg_file (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic wrEn,
	input wire logic [sec_pkg::IDX_W-1:0] wrIdx,
	input wire logic [7:0] wrData,
	input wire logic rdEn,
	input wire logic rdHit,
	input wire logic [sec_pkg::IDX_W-1:0] rdIdx,
	output logic [7:0] rdData,
	output logic [sec_pkg::NUM_REGS*8-1:0] regs
);

	genvar i;
	generate
		for (i = 0; i < sec_pkg::NUM_REGS; i++)
		begin : g_byte
			always_ff @(posedge ref_clk or posedge rst)
			begin
				if (rst)
					regs[i*8 +: 8] <= sec_pkg::RST_VAL[i];
				else if (wrEn && wrIdx == sec_pkg::IDX_W'(i))
					regs[i*8 +: 8] <= wrData & sec_pkg::WR_MASK[i];
			end
		end
	endgenerate

	// Unmapped reads return zero
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			rdData <= 8'h00;
		else if (rdEn)
			rdData <= rdHit ? regs[rdIdx*8 +: 8] : 8'h00;
	end

endmodule : sec_reg_file

/* rtl/sec_config_regs.sv */
`timescale 1ns/10ps
// Overview of operation
// - Master modes: horizontal sync width from code 0-3 is 1, 4, 16, 128 cycles.
// - Vertical sync edge follows horizontal sync edge by 0, 4, 8 or 18 cycles.
// - Mode 1: rise-delay bit adds 32 us to sync delay; neighbour bit ignored.
// - Mode 2: vertical sync width from code is 1, 4, 16 or 128 cycles.
// - Pixel data start shifted 0 to 3 cycles after horizontal sync.
// - 32-bit subcarrier frequency from four bytes, low byte first, NTSC at reset.
// - Subcarrier phase: bits 9:2 from phase register, 1:0 from LSB register top.
// - Even-field extended and odd-field caption data, 16 bits each, low byte first.
// - Mask bits suppress pedestal per line 10 to 25, odd and even separately.
// - 20-bit CGMS over three registers, top nibble first; WSS uses low 14 bits.
// - Enables for CGMS CRC, CGMS odd, CGMS even and WSS in first register.
// - 10-bit luma and colour-difference scales, high bits own, low bits shared.
// - Hue adjusted by an 8-bit register value.
// - 7-bit brightness in bits 6:0; bit 7 blanks WSS data.
// - Shaping gain code -4 dB to +4 dB, only when filter selected; upper bits zero.
// - Coring gains border and data, +n/16 normally, -n/8 in noise reducer mode.
module sec_config_regs #(
	parameter int unsigned RiseExtCycles = sec_pkg::RISE_EXT_CYC
) (
	input wire logic ref_clk,
	input wire logic rst,
	input sec_pkg::sec_host_req_t hostReq,
	output logic [7:0] hostRdData,
	output logic hostRdValid,
	input wire logic masterMode,
	input wire logic [1:0] timingMode,
	input wire logic lumaShapingFilterSel,
	input wire logic noiseReducerMode,
	input wire logic lineStart,
	input wire logic fieldStart,
	input wire logic fieldEnd,
	output sec_pkg::sec_cfg_t cfg,
	output sec_pkg::sec_sync_t sync
);

	logic [sec_pkg::NUM_REGS*8-1:0] regs;
	logic [7:0] offset;
	logic addrHit;
	logic [sec_pkg::IDX_W-1:0] regIdx;
	sec_pkg::sec_cfg_t next_cfg;

	// Register window decode
	assign offset = hostReq.subAddr - sec_pkg::SYNC_TIMING_ADDR;
	assign addrHit = (hostReq.subAddr >= sec_pkg::SYNC_TIMING_ADDR) &&
		(hostReq.subAddr <= sec_pkg::NOISE_CORING_ADDR);
	assign regIdx = offset[sec_pkg::IDX_W-1:0];

	sec_reg_file u_reg_file (
		.ref_clk(ref_clk),
		.rst(rst),
		.wrEn(hostReq.wrEn && addrHit),
		.wrIdx(regIdx),
		.wrData(hostReq.wrData),
		.rdEn(hostReq.rdEn),
		.rdHit(addrHit),
		.rdIdx(regIdx),
		.rdData(hostRdData),
		.regs(regs)
	);

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			hostRdValid <= 1'b0;
		else
			hostRdValid <= hostReq.rdEn;
	end

	// Callers must be procedural: the bank is read without being an argument
	function automatic logic [7:0] regAt(input logic [7:0] addr);
		logic [7:0] rel;
		rel = addr - sec_pkg::SYNC_TIMING_ADDR;
		return regs[rel[sec_pkg::IDX_W-1:0]*8 +: 8];
	endfunction : regAt

	// Coring code to signed sixteenths, clamped at the top code
	function automatic logic signed [5:0] coringGain(input logic [3:0] code,
		input logic reducer);
		logic [3:0] c;
		// Codes above 8 are undefined; clamping keeps the gain bounded
		c = (code > sec_pkg::CORING_MAX) ? sec_pkg::CORING_MAX : code;
		if (reducer)
			return -$signed({1'b0, c, 1'b0});
		else
			return $signed({2'b00, c});
	endfunction : coringGain

	// Field assembly
	always_comb
	begin
		logic [7:0] lsbs;
		logic [7:0] copyTop;
		logic [7:0] copyMid;
		logic [7:0] copyLow;
		logic [7:0] bright;
		logic [7:0] coring;
		logic [7:0] shaping;
		lsbs = regAt(sec_pkg::SCALE_LSBS_ADDR);
		copyTop = regAt(sec_pkg::COPY_CTRL_TOP_ADDR);
		copyMid = regAt(sec_pkg::COPY_DATA_MID_ADDR);
		copyLow = regAt(sec_pkg::COPY_DATA_LOW_ADDR);
		bright = regAt(sec_pkg::BRIGHTNESS_ADDR);
		coring = regAt(sec_pkg::NOISE_CORING_ADDR);
		shaping = regAt(sec_pkg::LUMA_SHAPING_ADDR);
		next_cfg.fscFreq = {regAt(sec_pkg::FSC_BYTE3_ADDR), regAt(sec_pkg::FSC_BYTE2_ADDR),
			regAt(sec_pkg::FSC_BYTE1_ADDR), regAt(sec_pkg::FSC_BYTE0_ADDR)};
		next_cfg.fscPhase = {regAt(sec_pkg::FSC_PHASE_ADDR),
			lsbs[sec_pkg::PHASE_LSB_POS +: 2]};
		next_cfg.captionEvenExt = {regAt(sec_pkg::CC_EVEN_HIGH_ADDR),
			regAt(sec_pkg::CC_EVEN_LOW_ADDR)};
		next_cfg.captionOdd = {regAt(sec_pkg::CC_ODD_HIGH_ADDR),
			regAt(sec_pkg::CC_ODD_LOW_ADDR)};
		// Bit 0 of each mask is line 10, bit 15 is line 25
		next_cfg.pedestalOffOdd = {regAt(sec_pkg::PED_ODD_B_ADDR),
			regAt(sec_pkg::PED_ODD_A_ADDR)};
		next_cfg.pedestalOffEven = {regAt(sec_pkg::PED_EVEN_B_ADDR),
			regAt(sec_pkg::PED_EVEN_A_ADDR)};
		next_cfg.cgmsData = {copyTop[sec_pkg::CGMS_TOP_LSB +: 4], copyMid, copyLow};
		next_cfg.wssData = {copyMid[5:0], copyLow};
		next_cfg.cgmsCrcEn = copyTop[sec_pkg::CGMS_CRC_BIT];
		next_cfg.cgmsOddEn = copyTop[sec_pkg::CGMS_ODD_BIT];
		next_cfg.cgmsEvenEn = copyTop[sec_pkg::CGMS_EVEN_BIT];
		next_cfg.wssEn = copyTop[sec_pkg::WSS_EN_BIT];
		next_cfg.lumaScale = {regAt(sec_pkg::LUMA_SCALE_ADDR),
			lsbs[sec_pkg::LUMA_LSB_POS +: 2]};
		next_cfg.blueDifferenceScale = {regAt(sec_pkg::BLUE_DIFF_SCALE_ADDR),
			lsbs[sec_pkg::BLUE_LSB_POS +: 2]};
		next_cfg.redDifferenceScale = {regAt(sec_pkg::RED_DIFF_SCALE_ADDR),
			lsbs[sec_pkg::RED_LSB_POS +: 2]};
		next_cfg.hueOffset = regAt(sec_pkg::HUE_ADDR);
		next_cfg.brightness = bright[6:0];
		next_cfg.wssBlank = bright[sec_pkg::WSS_BLANK_BIT];
		// Reserved upper bits are masked on write, so only the code is kept
		next_cfg.lumaShapingFilterGain = lumaShapingFilterSel ?
			shaping[3:0] : sec_pkg::SHAPING_UNITY;
		next_cfg.borderCoringGain = coringGain(coring[sec_pkg::BORDER_CORING_LSB +: 4],
			noiseReducerMode);
		next_cfg.dataCoringGain = coringGain(coring[sec_pkg::DATA_CORING_LSB +: 4],
			noiseReducerMode);
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			cfg <= '0;
		else
			cfg <= next_cfg;
	end

	// Sync timing generator, active only as timing master
	logic [7:0] syncTiming;
	logic [7:0] hsCnt;
	logic [7:0] next_hsCnt;
	logic [sec_pkg::CNT_W-1:0] vsCnt;
	logic [sec_pkg::CNT_W-1:0] next_vsCnt;
	sec_pkg::sec_vs_state_t vsState;
	sec_pkg::sec_vs_state_t next_vsState;
	logic [2:0] lineDly;
	logic [sec_pkg::CNT_W-1:0] delayB;
	logic [sec_pkg::CNT_W-1:0] delayC;
	logic [sec_pkg::CNT_W-1:0] vsWidth;
	logic lineGo;
	logic [1:0] pixAdj;
	logic hsyncN;
	logic vsyncN;
	logic pixelStart;

	function automatic logic [7:0] pulseCycles(input logic [1:0] code);
		unique case (code)
			2'b00: return sec_pkg::PULSE_CYC0;
			2'b01: return sec_pkg::PULSE_CYC1;
			2'b10: return sec_pkg::PULSE_CYC2;
			2'b11: return sec_pkg::PULSE_CYC3;
		endcase
	endfunction : pulseCycles

	function automatic logic [4:0] delayCycles(input logic [1:0] code);
		unique case (code)
			2'b00: return sec_pkg::DELAY_CYC0;
			2'b01: return sec_pkg::DELAY_CYC1;
			2'b10: return sec_pkg::DELAY_CYC2;
			2'b11: return sec_pkg::DELAY_CYC3;
		endcase
	endfunction : delayCycles

	// Procedural, so later register writes reach it through the function
	always_comb
	begin
		syncTiming = regAt(sec_pkg::SYNC_TIMING_ADDR);
	end
	assign lineGo = masterMode && lineStart;
	assign pixAdj = syncTiming[sec_pkg::PIX_ADJ_LSB +: 2];
	assign delayB = sec_pkg::CNT_W'(delayCycles(syncTiming[sec_pkg::HS_VS_DELAY_LSB +: 2]));
	// Mode 1 with the rise bit set stretches the rising edge; bit 5 is ignored
	assign delayC = (timingMode == sec_pkg::TIMING_MODE1 && syncTiming[sec_pkg::VS_RISE_EXT_BIT]) ?
		delayB + sec_pkg::CNT_W'(RiseExtCycles) : delayB;
	assign vsWidth = sec_pkg::CNT_W'(pulseCycles(syncTiming[sec_pkg::VS_WIDTH_LSB +: 2]));

	// Fields come from separate processes, so the struct gets one driver here
	assign sync = '{
		hsyncN: hsyncN,
		vsyncN: vsyncN,
		pixelStart: pixelStart
	};

	// Horizontal sync pulse counter
	always_comb
	begin
		// Slave mode parks the counter so hsync stays released
		if (!masterMode)
			next_hsCnt = 8'h00;
		else if (lineStart)
			next_hsCnt = pulseCycles(syncTiming[sec_pkg::HS_WIDTH_LSB +: 2]);
		else if (hsCnt != 8'h00)
			next_hsCnt = hsCnt - 8'h01;
		else
			next_hsCnt = 8'h00;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			hsCnt <= 8'h00;
			hsyncN <= 1'b1;
		end
		else
		begin
			hsCnt <= next_hsCnt;
			hsyncN <= (next_hsCnt == 8'h00);
		end
	end

	// Vertical sync sequencing
	always_comb
	begin
		next_vsState = vsState;
		next_vsCnt = vsCnt;
		if (!masterMode)
		begin
			next_vsState = sec_pkg::VS_IDLE;
			next_vsCnt = '0;
		end
		else
		begin
			unique case (vsState)
				sec_pkg::VS_IDLE:
				begin
					if (lineGo && fieldStart)
					begin
						if (delayB == '0)
						begin
							next_vsState = sec_pkg::VS_ACTIVE;
							next_vsCnt = vsWidth;
						end
						else
						begin
							next_vsState = sec_pkg::VS_DELAY;
							next_vsCnt = delayB;
						end
					end
				end
				sec_pkg::VS_DELAY:
				begin
					if (vsCnt == sec_pkg::CNT_W'(1))
					begin
						next_vsState = sec_pkg::VS_ACTIVE;
						next_vsCnt = vsWidth;
					end
					else
						next_vsCnt = vsCnt - sec_pkg::CNT_W'(1);
				end
				sec_pkg::VS_ACTIVE:
				begin
					if (timingMode == sec_pkg::TIMING_MODE2)
					begin
						// Fixed width pulse
						if (vsCnt == sec_pkg::CNT_W'(1))
							next_vsState = sec_pkg::VS_IDLE;
						else
							next_vsCnt = vsCnt - sec_pkg::CNT_W'(1);
					end
					else if (lineGo && fieldEnd)
					begin
						if (delayC == '0)
							next_vsState = sec_pkg::VS_IDLE;
						else
						begin
							next_vsState = sec_pkg::VS_TRAIL;
							next_vsCnt = delayC;
						end
					end
				end
				sec_pkg::VS_TRAIL:
				begin
					if (vsCnt == sec_pkg::CNT_W'(1))
						next_vsState = sec_pkg::VS_IDLE;
					else
						next_vsCnt = vsCnt - sec_pkg::CNT_W'(1);
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			vsState <= sec_pkg::VS_IDLE;
			vsCnt <= '0;
			vsyncN <= 1'b1;
		end
		else
		begin
			vsState <= next_vsState;
			vsCnt <= next_vsCnt;
			vsyncN <= !(next_vsState == sec_pkg::VS_ACTIVE ||
				next_vsState == sec_pkg::VS_TRAIL);
		end
	end

	// Pixel data start, delayed from the line start
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			lineDly <= 3'h0;
			pixelStart <= 1'b0;
		end
		else
		begin
			lineDly <= {lineDly[1:0], lineGo};
			// Stale line starts left in the delay line must not leak out in slave mode
			if (!masterMode)
				pixelStart <= 1'b0;
			else
				pixelStart <= (pixAdj == 2'h0) ? lineGo : lineDly[pixAdj - 2'h1];
		end
	end

endmodule : sec_config_regs

/* dv/sec_config_regs_asserts.sv */
`timescale 1ns/10ps
module sec_config_regs_asserts #(
	parameter int unsigned RiseExtCycles = 6400
) (
	input wire logic ref_clk,
	input wire logic rst,
	input sec_pkg::sec_host_req_t hostReq,
	input wire logic [7:0] hostRdData,
	input wire logic hostRdValid,
	input wire logic masterMode,
	input wire logic [1:0] timingMode,
	input wire logic lumaShapingFilterSel,
	input wire logic noiseReducerMode,
	input wire logic lineStart,
	input wire logic fieldStart,
	input wire logic fieldEnd,
	input sec_pkg::sec_cfg_t cfg,
	input sec_pkg::sec_sync_t sync
);
	logic [1:0] hsCode;

	// Shadow of the width code, rebuilt from host writes only
	always_ff @(posedge ref_clk or posedge rst)
		if (rst)
			hsCode <= 2'h0;
		else if (hostReq.wrEn && hostReq.subAddr == sec_pkg::SYNC_TIMING_ADDR)
			hsCode <= hostReq.wrData[1:0];

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence regWr(logic [7:0] a);
		hostReq.wrEn && hostReq.subAddr == a;
	endsequence
	sequence lineTaken;
		masterMode && lineStart;
	endsequence

	phase_map_a: assert property (regWr(sec_pkg::FSC_PHASE_ADDR) |=>
		##1 cfg.fscPhase[9:2] == $past(hostReq.wrData, 2)) else $error("phase high bits wrong");
	wss_enable_a: assert property (regWr(sec_pkg::COPY_CTRL_TOP_ADDR) |=>
		##1 cfg.wssEn == $past(hostReq.wrData[7], 2)) else $error("wss enable wrong");
	hue_map_a: assert property (regWr(sec_pkg::HUE_ADDR) |=>
		##1 cfg.hueOffset == $past(hostReq.wrData, 2)) else $error("hue wrong");
	bright_map_a: assert property (regWr(sec_pkg::BRIGHTNESS_ADDR) |=>
		##1 {cfg.wssBlank, cfg.brightness} == $past(hostReq.wrData, 2)) else $error("brightness wrong");
	hs_start_a: assert property (lineTaken |=> !sync.hsyncN)
		else $error("hsync did not start");
	hs_single_a: assert property (lineTaken ##0 hsCode == 2'h0 |=>
		!sync.hsyncN ##1 sync.hsyncN) else $error("one cycle hsync wrong");
	sync_idle_a: assert property (!masterMode [*2] |->
		sync.hsyncN && sync.vsyncN && !sync.pixelStart) else $error("sync active in slave");
	shaping_off_a: assert property ((!lumaShapingFilterSel && !rst) [*2] |->
		cfg.lumaShapingFilterGain == sec_pkg::SHAPING_UNITY) else $error("shaping gain not unity");
endmodule : sec_config_regs_asserts

bind sec_config_regs sec_config_regs_asserts #(.RiseExtCycles(RiseExtCycles)) u_chk (
	.ref_clk(ref_clk), .rst(rst), .hostReq(hostReq), .hostRdData(hostRdData),
	.hostRdValid(hostRdValid), .masterMode(masterMode), .timingMode(timingMode),
	.lumaShapingFilterSel(lumaShapingFilterSel), .noiseReducerMode(noiseReducerMode),
	.lineStart(lineStart), .fieldStart(fieldStart), .fieldEnd(fieldEnd),
	.cfg(cfg), .sync(sync)
);

/* dv/sec_config_regs_tb.sv */
`timescale 1ns/10ps
module sec_config_regs_tb;
	localparam int RX = 40;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	sec_pkg::sec_host_req_t hostReq = '0;
	logic [7:0] hostRdData;
	logic hostRdValid;
	logic masterMode = 1'b0;
	logic [1:0] timingMode = 2'h0;
	logic lumaShapingFilterSel = 1'b0;
	logic noiseReducerMode = 1'b0;
	logic lineStart = 1'b0;
	logic fieldStart = 1'b0;
	logic fieldEnd = 1'b0;
	sec_pkg::sec_cfg_t cfg;
	sec_pkg::sec_sync_t sync;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	int hsLow, vsLow, hsAt, vsAt, pixAt, cyc, d0;
	logic [7:0] q, r;
	logic [7:0] rstv [4] = '{8'h1f, 8'h7c, 8'hf0, 8'h21};
	int wid [4] = '{1, 4, 16, 128};
	int dly [4] = '{0, 4, 8, 18};

	always #2.5 ref_clk = ~ref_clk;

	// Short rise extension keeps the mode 1 case quick
	sec_config_regs #(.RiseExtCycles(RX)) u_dut (
		.ref_clk(ref_clk), .rst(rst), .hostReq(hostReq), .hostRdData(hostRdData),
		.hostRdValid(hostRdValid), .masterMode(masterMode), .timingMode(timingMode),
		.lumaShapingFilterSel(lumaShapingFilterSel), .noiseReducerMode(noiseReducerMode),
		.lineStart(lineStart), .fieldStart(fieldStart), .fieldEnd(fieldEnd),
		.cfg(cfg), .sync(sync)
	);

	function automatic logic [7:0] pat(input logic [7:0] a);
		return a ^ 8'ha5;
	endfunction : pat

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		hostReq <= '{wrEn: 1'b1, rdEn: 1'b0, subAddr: a, wrData: d};
		@(posedge ref_clk);
		hostReq <= '0;
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		hostReq <= '{wrEn: 1'b0, rdEn: 1'b1, subAddr: a, wrData: 8'h00};
		@(posedge ref_clk);
		hostReq <= '0;
		@(negedge ref_clk);
		chk({31'h0, hostRdValid}, 32'h1);
		chk({24'h0, hostRdData}, {24'h0, e});
	endtask : rdchk

	task automatic line(input logic fs, input logic fe, input int n);
		@(posedge ref_clk);
		lineStart <= 1'b1;
		fieldStart <= fs;
		fieldEnd <= fe;
		@(posedge ref_clk);
		lineStart <= 1'b0;
		fieldStart <= 1'b0;
		fieldEnd <= 1'b0;
		repeat (n) @(posedge ref_clk);
	endtask : line

	// Edge positions are kept relative to hsync, so output latency cancels out
	always @(posedge ref_clk)
	begin
		cycles <= cycles + 1;
		if (lineStart)
		begin
			cyc <= 0;
			hsLow <= 0;
			vsLow <= 0;
			pixAt <= -9;
		end
		else
		begin
			cyc <= cyc + 1;
			if (sync.hsyncN === 1'b0)
				hsLow <= hsLow + 1;
			if (sync.hsyncN === 1'b0 && hsLow == 0)
				hsAt <= cyc;
			if (sync.vsyncN === 1'b0)
				vsLow <= vsLow + 1;
			if (sync.vsyncN === 1'b0 && vsLow == 0)
				vsAt <= cyc;
			if (sync.pixelStart === 1'b1)
				pixAt <= cyc;
		end
		// Ceiling well above the roughly 1340 cycles the tests need
		if (cycles == 5000)
		begin
			num_errors++;
			$display("MISMATCH t=%0t timeout", $time);
			close_out();
		end
	end

	initial
	begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		for (int a = 8'h8a; a <= 8'ha4; a++)
			rdchk(8'(a), (a >= 8'h8c && a <= 8'h8f) ? rstv[a - 8'h8c] : 8'h00);
		chk(cfg.fscFreq, 32'h21f07c1f);
		chk(32'(cfg.lumaShapingFilterGain), 32'h6);
		$display("test reset values done");
		for (int a = 8'h8b; a <= 8'ha4; a++)
			wr(8'(a), pat(8'(a)));
		for (int a = 8'h8a; a <= 8'ha4; a++)
			rdchk(8'(a), (a < 8'h8b || a > 8'ha3) ? 8'h00 : pat(8'(a)) & (a == 8'ha2 ? 8'h0f : 8'hff));
		@(posedge ref_clk);
		lumaShapingFilterSel <= 1'b1;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		chk(cfg.fscFreq, {pat(8'h8f), pat(8'h8e), pat(8'h8d), pat(8'h8c)});
		q = pat(8'h9c);
		chk(32'(cfg.fscPhase), 32'({pat(8'h90), q[7:6]}));
		chk(32'(cfg.lumaScale), 32'({pat(8'h9d), q[1:0]}));
		chk(32'(cfg.blueDifferenceScale), 32'({pat(8'h9e), q[3:2]}));
		chk(32'(cfg.redDifferenceScale), 32'({pat(8'h9f), q[5:4]}));
		chk({cfg.captionEvenExt, cfg.captionOdd}, {pat(8'h92), pat(8'h91), pat(8'h94), pat(8'h93)});
		chk({cfg.pedestalOffOdd, cfg.pedestalOffEven}, {pat(8'h96), pat(8'h95), pat(8'h98), pat(8'h97)});
		q = pat(8'h99);
		r = pat(8'h9a);
		chk(32'(cfg.cgmsData), 32'({q[3:0], r, pat(8'h9b)}));
		chk(32'(cfg.wssData), 32'({r[5:0], pat(8'h9b)}));
		chk(32'({cfg.wssEn, cfg.cgmsEvenEn, cfg.cgmsOddEn, cfg.cgmsCrcEn}), 32'(q[7:4]));
		chk(32'({cfg.wssBlank, cfg.brightness, cfg.hueOffset}), 32'({pat(8'ha1), pat(8'ha0)}));
		chk(32'(cfg.lumaShapingFilterGain), 32'h7);
		chk(32'({cfg.dataCoringGain, cfg.borderCoringGain}), 32'({6'h00, 6'h06}));
		@(posedge ref_clk);
		noiseReducerMode <= 1'b1;
		lumaShapingFilterSel <= 1'b0;
		wr(8'ha3, 8'h9f);
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		chk(32'({cfg.dataCoringGain, cfg.borderCoringGain}), 32'({6'h30, 6'h30}));
		chk(32'(cfg.lumaShapingFilterGain), 32'h6);
		$display("test field map done");
		@(posedge ref_clk);
		masterMode <= 1'b1;
		timingMode <= sec_pkg::TIMING_MODE2;
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h8b, 8'(i * 8'h55));
			line(1'b1, 1'b0, 200);
			chk(hsLow, wid[i]);
			chk(vsLow, wid[i]);
			chk(vsAt - hsAt, dly[i]);
			chk(pixAt - hsAt, i);
		end
		$display("test sync codes done");
		@(posedge ref_clk);
		timingMode <= sec_pkg::TIMING_MODE1;
		for (int j = 0; j < 2; j++)
		begin
			wr(8'h8b, j ? 8'h30 : 8'h20);
			line(1'b1, 1'b0, 20);
			line(1'b0, 1'b1, 120);
			if (j == 0)
				d0 = vsLow;
			else
				chk(vsLow - d0, RX);
		end
		$display("test rise delay done");
		@(posedge ref_clk);
		masterMode <= 1'b0;
		line(1'b1, 1'b0, 50);
		chk(hsLow + vsLow, 0);
		$display("test slave idle done");
		close_out();
	end
endmodule : sec_config_regs_tb
